// File: hw/seep_slave.sv
`timescale 1ns/1ns
// Function
// - Accept select only if type code and strap field match the strap pins.
// - Select bit 0 is direction: one reads, zero writes.
// - Matching select is acknowledged in slot nine; mismatch releases and idles.
// - Write select is followed by two acknowledged address bytes, then acknowledged data.
// - Address is thirteen bits, upper byte first (only its low five bits used), lower byte second.
// - Write guard high from Start through address end protects the top quarter.
// - Programming starts only on Stop in the slot right after a data acknowledge.
// - During programming the data driver is off and the bus is ignored.
// - Busy device gives no select acknowledge; afterwards it acknowledges normally.
// - Page write takes up to 32 bytes, incrementing only the low five bits.
// - Reads behave the same whatever the write guard level.
// - Random read: dummy write of address, repeated Start, read select.
// - Read select returns byte at address counter, then advances counter.
// - Each master acknowledge fetches the next consecutive byte.
// - Read counter wraps from the last location to zero.
// - No acknowledge after a read byte stops driving and enters standby.
// - Start is SDA falling while SCL high, watched except while programming.
// - Stop is SDA rising while SCL high and ends the communication.
// - SDA bits are captured on rising SCL edges.
// - Only a clear high on the write guard blocks; floating reads as low.
module seep_slave #(
    parameter logic [3:0] DEV_TYPE = seep_pkg::DEV_TYPE_DFLT,
    parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES_DFLT
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic scl_link,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic write_guard_n,
    input wire logic strap_sel_bit0,
    input wire logic strap_sel_bit1,
    input wire logic strap_sel_bit2
);
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);
    localparam logic [PCW-1:0] PAGE_END = PCW'(seep_pkg::PAGE_BYTES);

    function automatic logic is_top(input logic [seep_pkg::ADDR_W-1:0] a);
        is_top = (a[12:11] == seep_pkg::TOP_QUARTER);
    endfunction

    // Link side: each rising SCL edge samples SDA and flips a toggle.
    logic lrst_m, lrst_q, lbit_q, ltog_q;
    always_ff @(posedge scl_link) begin
        lrst_m <= srst;
        lrst_q <= lrst_m;
    end

    always_ff @(posedge scl_link) begin
        if (lrst_q) begin
            ltog_q <= 1'b0;
        end else begin
            ltog_q <= ~ltog_q;
        end
        lbit_q <= sda_i;
    end

    // The sampled bit stays put for a whole SCL period, far longer than the
    // toggle takes to cross, so it is read once the toggle edge arrives.
    logic [6:0] pin_m, pin_s;
    logic scl_p, sda_p, tog_p;
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_m <= seep_pkg::PIN_RESET;
            pin_s <= seep_pkg::PIN_RESET;
            scl_p <= seep_pkg::PIN_RESET[0];
            sda_p <= seep_pkg::PIN_RESET[1];
            tog_p <= 1'b0;
        end else begin
            pin_m <= {ltog_q, write_guard_n, strap_sel_bit2, strap_sel_bit1,
                      strap_sel_bit0, sda_i, scl_link};
            pin_s <= pin_m;
            scl_p <= pin_s[0];
            sda_p <= pin_s[1];
            tog_p <= pin_s[6];
        end
    end

    logic scl_s, sda_s, wg_s, tog_s;
    logic [2:0] strap_s;
    assign scl_s = pin_s[0];
    assign sda_s = pin_s[1];
    assign strap_s = pin_s[4:2];
    assign wg_s = pin_s[5];
    assign tog_s = pin_s[6];

    logic rx_ev, scl_fall, start_det, stop_det;
    assign rx_ev = tog_s ^ tog_p;
    assign scl_fall = scl_p & ~scl_s;
    assign start_det = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

    seep_pkg::seep_state_t st_q;
    seep_pkg::seep_phase_t ph_q;
    logic [3:0] bcnt_q;
    logic [7:0] sr_q, tx_q, mem_rd;
    logic [seep_pkg::ADDR_W-1:0] addr_q, addr_inc, addr_page_nxt;
    logic oe_q, guard_q, wr_pend_q, rd_q;
    logic [PCW-1:0] pcnt_q;
    logic [seep_pkg::PAGE_BYTES-1:0] mask_q;
    logic [7:0] mem [seep_pkg::MEM_DEPTH];
    logic [7:0] pbuf [seep_pkg::PAGE_BYTES];

    logic byte_done, sel_ok, data_we, rd_load, prog_go, prog_done, mem_we;
    assign byte_done = (st_q == seep_pkg::ST_RX) && (bcnt_q == seep_pkg::BIT_ACK_SLOT)
                       && scl_fall;
    assign sel_ok = (sr_q[7:4] == DEV_TYPE) && (sr_q[3:1] == strap_s);
    assign data_we = byte_done && (ph_q == seep_pkg::PH_DATA);
    assign rd_load = (byte_done && (ph_q == seep_pkg::PH_SEL) && sel_ok
                      && sr_q[seep_pkg::SEL_DIR_BIT])
                     || ((st_q == seep_pkg::ST_TACK) && rx_ev && !lbit_q);
    assign prog_go = stop_det && (st_q == seep_pkg::ST_RX) && (ph_q == seep_pkg::PH_DATA)
                     && (bcnt_q <= seep_pkg::BIT_STOP_SLOT) && wr_pend_q;
    assign prog_done = (pcnt_q == PROG_LAST);
    assign mem_we = (st_q == seep_pkg::ST_PROG) && (pcnt_q < PAGE_END)
                    && mask_q[pcnt_q[seep_pkg::PAGE_W-1:0]]
                    && !(guard_q && is_top(addr_q));
    assign mem_rd = mem[addr_q];
    assign addr_inc = addr_q + 13'h0001;
    assign addr_page_nxt = {addr_q[12:5], addr_q[4:0] + 5'h01};
    assign sda_o = 1'b0;
    assign sda_oe = oe_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= seep_pkg::ST_IDLE;
            ph_q <= seep_pkg::PH_SEL;
            bcnt_q <= 4'h0;
            sr_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            addr_q <= '0;
            guard_q <= 1'b0;
            wr_pend_q <= 1'b0;
            rd_q <= 1'b0;
        end else if (st_q == seep_pkg::ST_PROG) begin
            // Start, Stop and clocks are all ignored, so polling selects go unanswered.
            oe_q <= 1'b0;
            if (prog_done) begin
                st_q <= seep_pkg::ST_IDLE;
            end
        end else if (prog_go) begin
            st_q <= seep_pkg::ST_PROG;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
        end else if (start_det) begin
            // A repeated Start keeps the address counter for a random read.
            st_q <= seep_pkg::ST_RX;
            ph_q <= seep_pkg::PH_SEL;
            bcnt_q <= 4'h0;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
            guard_q <= wg_s;
        end else if (stop_det) begin
            st_q <= seep_pkg::ST_IDLE;
            oe_q <= 1'b0;
            wr_pend_q <= 1'b0;
        end else begin
            if (st_q != seep_pkg::ST_IDLE && ph_q != seep_pkg::PH_DATA) begin
                guard_q <= guard_q | wg_s;
            end
            case (st_q)
                seep_pkg::ST_RX: begin
                    if (rx_ev && bcnt_q < seep_pkg::BIT_ACK_SLOT) begin
                        sr_q <= {sr_q[6:0], lbit_q};
                        bcnt_q <= bcnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        bcnt_q <= 4'h0;
                        st_q <= seep_pkg::ST_ACK;
                        oe_q <= 1'b1;
                        case (ph_q)
                            seep_pkg::PH_SEL: begin
                                if (!sel_ok) begin
                                    st_q <= seep_pkg::ST_IDLE;
                                    oe_q <= 1'b0;
                                end else if (sr_q[seep_pkg::SEL_DIR_BIT]) begin
                                    rd_q <= 1'b1;
                                    tx_q <= mem_rd;
                                    addr_q <= addr_inc;
                                end else begin
                                    rd_q <= 1'b0;
                                    ph_q <= seep_pkg::PH_AHI;
                                end
                            end
                            seep_pkg::PH_AHI: begin
                                addr_q[12:8] <= sr_q[4:0];
                                ph_q <= seep_pkg::PH_ALO;
                            end
                            seep_pkg::PH_ALO: begin
                                addr_q[7:0] <= sr_q;
                                ph_q <= seep_pkg::PH_DATA;
                            end
                            default: begin
                                addr_q <= addr_page_nxt;
                                wr_pend_q <= 1'b1;
                            end
                        endcase
                    end
                end
                seep_pkg::ST_ACK: begin
                    if (rx_ev) begin
                        bcnt_q <= seep_pkg::BIT_STOP_SLOT;
                    end else if (scl_fall && bcnt_q == seep_pkg::BIT_STOP_SLOT) begin
                        bcnt_q <= 4'h0;
                        if (rd_q) begin
                            st_q <= seep_pkg::ST_TX;
                            oe_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end else begin
                            st_q <= seep_pkg::ST_RX;
                            oe_q <= 1'b0;
                        end
                    end
                end
                seep_pkg::ST_TX: begin
                    if (rx_ev) begin
                        bcnt_q <= bcnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bcnt_q == seep_pkg::BIT_ACK_SLOT) begin
                            st_q <= seep_pkg::ST_TACK;
                            oe_q <= 1'b0;
                        end else begin
                            if (bcnt_q == seep_pkg::BIT_RESUME) begin
                                bcnt_q <= 4'h0;
                            end
                            oe_q <= ~tx_q[7];
                            tx_q <= {tx_q[6:0], 1'b0};
                        end
                    end
                end
                seep_pkg::ST_TACK: begin
                    if (rx_ev) begin
                        if (!lbit_q) begin
                            // Read path never looks at the write guard.
                            tx_q <= mem_rd;
                            addr_q <= addr_inc;
                            st_q <= seep_pkg::ST_TX;
                            bcnt_q <= seep_pkg::BIT_RESUME;
                        end else begin
                            st_q <= seep_pkg::ST_IDLE;
                        end
                    end
                end
                seep_pkg::ST_IDLE: begin
                    oe_q <= 1'b0;
                end
                default: begin
                    st_q <= seep_pkg::ST_IDLE;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Page latch mask: cleared by each matching write select, set per data byte received.
    always_ff @(posedge clock) begin
        if (srst) begin
            mask_q <= '0;
        end else if (byte_done && ph_q == seep_pkg::PH_SEL && sel_ok
                     && !sr_q[seep_pkg::SEL_DIR_BIT]) begin
            mask_q <= '0;
        end else if (data_we) begin
            mask_q[addr_q[seep_pkg::PAGE_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || st_q != seep_pkg::ST_PROG) begin
            pcnt_q <= '0;
        end else begin
            pcnt_q <= pcnt_q + 1'b1;
        end
    end

    // The row stays in the counter during programming, so it places the page.
    always_ff @(posedge clock) begin
        if (data_we) begin
            pbuf[addr_q[seep_pkg::PAGE_W-1:0]] <= sr_q;
        end
        if (mem_we) begin
            mem[{addr_q[12:5], pcnt_q[seep_pkg::PAGE_W-1:0]}] <=
                pbuf[pcnt_q[seep_pkg::PAGE_W-1:0]];
        end
    end

    property p_nomatch;
        @(posedge clock) disable iff (srst)
        byte_done && ph_q == seep_pkg::PH_SEL && !sel_ok
        |=> st_q == seep_pkg::ST_IDLE ##1 !sda_oe;
    endproperty
    a_nomatch: assert property (p_nomatch)
        else $error("mismatching select was answered");

    property p_sel_ack;
        @(posedge clock) disable iff (srst)
        byte_done && ph_q == seep_pkg::PH_SEL && sel_ok
        |=> sda_oe && st_q == seep_pkg::ST_ACK;
    endproperty
    a_sel_ack: assert property (p_sel_ack)
        else $error("matching select not acknowledged");

    property p_prog_quiet;
        @(posedge clock) disable iff (srst)
        st_q == seep_pkg::ST_PROG && $past(st_q) == seep_pkg::ST_PROG
        |-> !sda_oe && $stable(addr_q);
    endproperty
    a_prog_quiet: assert property (p_prog_quiet)
        else $error("bus activity during programming");

    property p_no_trig;
        @(posedge clock) disable iff (srst)
        stop_det && st_q != seep_pkg::ST_PROG && !prog_go
        |=> st_q == seep_pkg::ST_IDLE;
    endproperty
    a_no_trig: assert property (p_no_trig)
        else $error("stop in wrong slot started programming");

    property p_page;
        @(posedge clock) disable iff (srst)
        data_we |=> sda_oe && addr_q[12:5] == $past(addr_q[12:5])
                    && addr_q[4:0] == $past(addr_q[4:0]) + 5'h01;
    endproperty
    a_page: assert property (p_page)
        else $error("page address did not wrap in row");

    property p_rd_inc;
        @(posedge clock) disable iff (srst)
        rd_load && !start_det && !stop_det
        |=> addr_q == $past(addr_q) + 13'h0001 && tx_q == $past(mem_rd);
    endproperty
    a_rd_inc: assert property (p_rd_inc)
        else $error("read byte or counter step wrong");

    property p_nack;
        @(posedge clock) disable iff (srst)
        st_q == seep_pkg::ST_TACK && rx_ev && lbit_q && !start_det && !stop_det
        |=> st_q == seep_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_nack: assert property (p_nack)
        else $error("no standby after master nack");

    property p_start;
        @(posedge clock) disable iff (srst)
        start_det && st_q != seep_pkg::ST_PROG && !prog_go
        |=> st_q == seep_pkg::ST_RX && ph_q == seep_pkg::PH_SEL && bcnt_q == 4'h0;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");

    property p_guard;
        @(posedge clock) disable iff (srst)
        st_q != seep_pkg::ST_IDLE && st_q != seep_pkg::ST_PROG
        && ph_q != seep_pkg::PH_DATA && wg_s && !stop_det && !prog_go
        |=> guard_q;
    endproperty
    a_guard: assert property (p_guard)
        else $error("write guard not latched");
endmodule

// File: common/seep_pkg.sv
package seep_pkg;
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;
    localparam int SEL_DIR_BIT = 0;
    localparam logic [1:0] TOP_QUARTER = 2'h3;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_STOP_SLOT = 4'h1;
    localparam logic [3:0] BIT_RESUME = 4'hf;
    // SCL and SDA reset to their idle high level, so no false edge follows reset.
    localparam logic [6:0] PIN_RESET = 7'h03;
    // Device type code; the value is arbitrary.
    localparam logic [3:0] DEV_TYPE_DFLT = 4'h6;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h3,
        ST_TX = 3'h2,
        ST_TACK = 3'h6,
        ST_PROG = 3'h4
    } seep_state_t;

    typedef enum logic [1:0] {
        PH_SEL = 2'h0,
        PH_AHI = 2'h1,
        PH_ALO = 2'h3,
        PH_DATA = 2'h2
    } seep_phase_t;
endpackage

// File: verification/seep_master.sv
`timescale 1ns/1ns
// Two-wire bus master. The low phase of SCL is stretched so that the
// slave's synchronised answer settles before each rising edge.
module seep_master #(
    parameter int LOW_NS = 65,
    parameter int HIGH_NS = 60
) (
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic start();
        sda_pull = 1'b0;
        #(LOW_NS);
        scl = 1'b1;
        #(HIGH_NS / 2);
        sda_pull = 1'b1;
        #(HIGH_NS / 2);
        scl = 1'b0;
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #(LOW_NS);
        scl = 1'b1;
        #(HIGH_NS / 2);
        sda_pull = 1'b0;
        #(HIGH_NS / 2);
    endtask

    // Nine bit slots, MSB first; SDA only moves while SCL is low.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = ~tx[i];
            #(LOW_NS);
            scl = 1'b1;
            rx[i] = sda;
            #(HIGH_NS);
            scl = 1'b0;
        end
    endtask
endmodule

// File: verification/test_i2c_serial_eeprom_slave_protocol.sv
`timescale 1ns/1ns
module test_i2c_serial_eeprom_slave_protocol;
    // Type code is arbitrary.
    localparam logic [3:0] DEV = 4'h9;
    localparam logic [2:0] STRAP = 3'h5;
    localparam int WATCHDOG_NS = 1000000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic write_guard_n = 1'b0;
    logic [2:0] straps = STRAP;
    logic scl;
    logic pull;
    logic sda_oe;
    logic sda_o;
    wire logic sda_wire = ~(pull | (sda_oe & ~sda_o));
    int bad_count = 0;
    int total_checks = 0;

    always #10 clock = ~clock;

    seep_slave #(.DEV_TYPE(DEV), .PROG_CYCLES(64)) seep_slave_i (
        .clock(clock), .srst(srst), .scl_link(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe(sda_oe), .write_guard_n(write_guard_n), .strap_sel_bit0(straps[0]),
        .strap_sel_bit1(straps[1]), .strap_sel_bit2(straps[2]));

    seep_master seep_master_i (.scl(scl), .sda_pull(pull), .sda(sda_wire));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    // Sends a byte; returns the SDA level of the ninth slot (0 is acknowledge).
    task automatic put(input logic [7:0] b, output logic ack);
        logic [8:0] rx;
        seep_master_i.xfer({b, 1'b1}, rx);
        ack = rx[0];
    endtask

    task automatic get(input logic more, output logic [7:0] b);
        logic [8:0] rx;
        seep_master_i.xfer({8'hff, ~more}, rx);
        b = rx[8:1];
    endtask

    task automatic addr_phase(input logic [15:0] a);
        logic k;
        seep_master_i.start();
        put({DEV, STRAP, 1'b0}, k);
        check1(k, 1'b0);
        put(a[15:8], k);
        check1(k, 1'b0);
        put(a[7:0], k);
        check1(k, 1'b0);
    endtask

    // Repeats Start and a write select until acknowledged or 40 tries are spent, then sends Stop.
    task automatic poll(output int tries);
        logic k;
        tries = 0;
        k = 1'b1;
        while (k !== 1'b0 && tries < 40) begin
            seep_master_i.start();
            put({DEV, STRAP, 1'b0}, k);
            tries++;
        end
        seep_master_i.stop();
    endtask

    task automatic write_cmd(input logic [15:0] a, input logic [7:0] d[$]);
        logic k;
        int tries;
        addr_phase(a);
        foreach (d[i]) begin
            put(d[i], k);
            check1(k, 1'b0);
        end
        seep_master_i.stop();
        poll(tries);
        check1(tries > 1 && tries < 40, 1'b1);
    endtask

    task automatic read_seq(input logic [15:0] a, input logic [7:0] e[$]);
        logic k;
        logic [7:0] b;
        addr_phase(a);
        seep_master_i.start();
        put({DEV, STRAP, 1'b1}, k);
        check1(k, 1'b0);
        foreach (e[i]) begin
            get(i < e.size() - 1, b);
            check8(b, e[i]);
        end
        #150;
        check1(sda_oe, 1'b0);
        seep_master_i.stop();
    endtask

    task automatic cur_read(input logic [7:0] e);
        logic k;
        logic [7:0] b;
        seep_master_i.start();
        put({DEV, STRAP, 1'b1}, k);
        check1(k, 1'b0);
        get(1'b0, b);
        check8(b, e);
        seep_master_i.stop();
    endtask

    task automatic t_select();
        logic k;
        logic [7:0] s;
        for (int i = 0; i < 4; i++) begin
            s = (i == 0) ? {~DEV, STRAP, 1'b0} : {DEV, STRAP ^ (3'h1 << (i - 1)), 1'b0};
            seep_master_i.start();
            put(s, k);
            check1(k, 1'b1);
            seep_master_i.stop();
        end
        for (int i = 0; i < 2; i++) begin
            seep_master_i.start();
            put({DEV, STRAP, 1'b0}, k);
            check1(k, 1'b0);
            seep_master_i.stop();
        end
    endtask

    task automatic t_page();
        write_cmd(16'h0020, '{8'h11, 8'h22, 8'h33, 8'h44});
        write_cmd(16'h003c, '{8'ha1, 8'ha2, 8'ha3, 8'ha4});
        cur_read(8'h11);
        cur_read(8'h22);
        read_seq(16'h003c, '{8'ha1, 8'ha2, 8'ha3, 8'ha4});
        read_seq(16'h0020, '{8'h11, 8'h22});
    endtask

    task automatic t_wrap();
        write_cmd(16'h1fff, '{8'h77});
        write_cmd(16'h0000, '{8'h88});
        read_seq(16'h1fff, '{8'h77, 8'h88});
    endtask

    task automatic t_guard();
        write_cmd(16'h1800, '{8'h5a});
        @(posedge clock);
        #2 write_guard_n = 1'b1;
        write_cmd(16'h1800, '{8'ha5});
        write_cmd(16'hf000, '{8'h3c});
        read_seq(16'h1800, '{8'h5a});
        read_seq(16'h1000, '{8'h3c});
    endtask

    task automatic t_abort();
        logic k;
        addr_phase(16'h0022);
        seep_master_i.stop();
        seep_master_i.start();
        put({DEV, STRAP, 1'b0}, k);
        check1(k, 1'b0);
        seep_master_i.stop();
        read_seq(16'h0022, '{8'h33});
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        logic [8:0] rx;
        #7;
        seep_master_i.xfer(9'h1ff, rx);
        @(posedge clock);
        #2 srst = 1'b0;
        repeat (5) @(posedge clock);
        #2;
        t_select();
        t_page();
        t_wrap();
        t_guard();
        t_abort();
        report_and_stop();
    end

    initial begin
        #(WATCHDOG_NS);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
